// *** bench/loop_irq_enable_thread_entry_test.sv ***
// testbench for the loop / irq-enable / thread-entry execution block
// assumes lie_exec with memories answering in the same cycle, inputs driven on falling edge
`timescale 1ns/1ns
`default_nettype none
module loop_irq_enable_thread_entry_test;
    import lie_pkg::*;
    // ------------------------------------------------------------
    // stimulus and observed signals
    // ------------------------------------------------------------
    logic        core_clk, resetn, instr_valid, irq_pin;  // clock, reset, strobes
    logic [7:0]  instr_opcode, instr_operand, wreg_rdata;  // instruction fields, register read data
    logic [7:0]  register_page_pointer, wreg_base;         // page state
    logic [15:0] pc_in, sp_in, pmem_rdata;                 // word inputs
    logic        wreg_we, sp_we, stack_we, pc_we, flags_we, loop_unsupported, irq_take, busy;
    logic [7:0]  wreg_wdata, system_mode_reg;
    logic [15:0] sp_out, stack_addr, stack_wdata, pc_out, pmem_addr, thread_instr_pointer;
    logic [15:0] cap_wreg, cap_sp, cap_addr, cap_data, cap_pc;  // last strobed values
    int          n_wreg, n_pc, n_flags, n_take;                 // strobe counts
    int          n_errors, n_checks;                            // verdict counters

    lie_exec dut (.core_clk(core_clk), .resetn(resetn), .instr_valid(instr_valid),
        .instr_opcode(instr_opcode), .instr_operand(instr_operand), .pc_in(pc_in),
        .wreg_rdata(wreg_rdata), .register_page_pointer(register_page_pointer),
        .wreg_base(wreg_base), .sp_in(sp_in), .pmem_rdata(pmem_rdata), .irq_pin(irq_pin),
        .wreg_we(wreg_we), .wreg_wdata(wreg_wdata), .sp_we(sp_we), .sp_out(sp_out),
        .stack_we(stack_we), .stack_addr(stack_addr), .stack_wdata(stack_wdata),
        .pc_we(pc_we), .pc_out(pc_out), .pmem_addr(pmem_addr),
        .thread_instr_pointer(thread_instr_pointer), .system_mode_reg(system_mode_reg),
        .flags_we(flags_we), .loop_unsupported(loop_unsupported), .irq_take(irq_take),
        .busy(busy));

    // 50 MHz core clock
    always #10 core_clk = ~core_clk;

    // capture one-cycle strobes at the falling edge, where they have settled
    always @(negedge core_clk)
    begin
        if (wreg_we === 1'b1)
        begin
            cap_wreg = {8'h00, wreg_wdata};
            n_wreg++;
        end
        if (sp_we === 1'b1)
            cap_sp = sp_out;
        if (stack_we === 1'b1)
        begin
            cap_addr = stack_addr;
            cap_data = stack_wdata;
        end
        if (pc_we === 1'b1)
        begin
            cap_pc = pc_out;
            n_pc++;
        end
        if (flags_we !== 1'b0)
            n_flags++;
        if (irq_take === 1'b1)
            n_take++;
    end

    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    // compare and count
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
            n_errors++;
        end
    endtask : chk

    // issue one opcode, count busy cycles; poke retries a loop while busy
    task automatic run(input logic [7:0] opc, input int len, input logic poke);
        int n;
        n = 0;
        n_wreg = 0;
        n_pc = 0;
        @(negedge core_clk);
        instr_valid = 1'b1;
        instr_opcode = opc;
        @(negedge core_clk);
        instr_valid = 1'b0;
        while (busy === 1'b1 && n < 40)
        begin
            n++;
            instr_valid = poke && n == 4;  // must be ignored while busy
            instr_opcode = 8'h1A;
            @(negedge core_clk);
        end
        chk(16'(n), 16'(len - 1));
    endtask : run

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    // loop with a chosen register value and offset
    task automatic loop_case(input logic [7:0] val, input logic [7:0] off, input logic tk);
        wreg_rdata = val;
        instr_operand = off;
        pc_in = 16'h1000;
        run({4'h3, LOOP_OPC_LOW}, tk ? LOOP_TAKEN_CYC : LOOP_FALL_CYC, 1'b0);
        chk({8'h00, val - 8'h01}, cap_wreg);
        chk(cap_pc, tk ? 16'h1000 + {{8{off[7]}}, off} : 16'h1000);
        chk(16'(n_wreg), 16'h0001);
        chk(16'(n_pc), 16'h0001);
    endtask : loop_case

    // restricted page / working area combinations are flagged
    task automatic unsup_case(input logic [7:0] pg, input logic [7:0] base, input logic exp);
        register_page_pointer = pg;
        wreg_base = base;
        wreg_rdata = 8'h05;
        run({4'h7, LOOP_OPC_LOW}, LOOP_TAKEN_CYC, 1'b0);
        chk({15'h0000, loop_unsupported}, {15'h0000, exp});
    endtask : unsup_case

    // wait a bounded span for a grant
    task automatic wait_take(input int lim);
        for (int i = 0; i < lim && n_take == 0; i++) @(negedge core_clk);
    endtask : wait_take

    // request while disabled is kept, then served after enable; then live request
    task automatic irq_case;
        n_take = 0;
        irq_pin = 1'b1;
        repeat (12) @(negedge core_clk);
        chk(16'(n_take), 16'h0000);
        irq_pin = 1'b0;
        run(IRQ_ON_OPC, IRQ_ON_CYC, 1'b0);
        chk({8'h00, system_mode_reg}, 16'h0001);
        wait_take(20);
        chk(16'(n_take != 0), 16'h0001);
        repeat (4) @(negedge core_clk);
        n_take = 0;
        irq_pin = 1'b1;
        wait_take(20);
        irq_pin = 1'b0;
        chk(16'(n_take != 0), 16'h0001);
        repeat (4) @(negedge core_clk);
    endtask : irq_case

    // entry: push pointer, pointer from pc, pc from program word, pointer advances
    task automatic entry_case(input logic [15:0] sp, input logic [15:0] pc,
                              input logic [15:0] word, input logic [15:0] old_ip);
        sp_in = sp;
        pc_in = pc;
        pmem_rdata = word;
        run(ENTRY_OPC, ENTRY_CYC, 1'b1);
        chk(cap_sp, sp - 16'h0002);
        chk(cap_addr, sp - 16'h0002);
        chk(cap_data, old_ip);
        chk(pmem_addr, pc);
        chk(cap_pc, word);
        chk(thread_instr_pointer, pc + 16'h0002);
        chk(16'(n_wreg), 16'h0000);
        chk(16'(n_pc), 16'h0001);
    endtask : entry_case

    // closing verdict
    task automatic end_of_test;
        if (n_errors == 0 && n_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : end_of_test

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial
    begin
        {core_clk, resetn, instr_valid, irq_pin} = 4'h0;
        {instr_opcode, instr_operand, wreg_rdata} = 24'h000000;
        register_page_pointer = 8'h00;
        wreg_base = 8'hC0;
        {pc_in, sp_in, pmem_rdata} = 48'h000000000000;
        n_wreg = 0;
        n_pc = 0;
        n_flags = 0;
        n_take = 0;
        n_errors = 0;
        n_checks = 0;
        repeat (6) @(negedge core_clk);
        resetn = 1'b1;
        chk({8'h00, system_mode_reg}, {8'h00, MODE_RESET});
        irq_case();
        loop_case(8'h02, 8'hF0, 1'b1);
        loop_case(8'h01, 8'h10, 1'b0);
        loop_case(8'h00, 8'h05, 1'b1);
        unsup_case(8'h11, 8'h20, 1'b1);
        unsup_case(8'h10, 8'h00, 1'b1);
        unsup_case(8'h10, 8'hC0, 1'b0);
        unsup_case(8'h11, 8'hC8, 1'b0);
        unsup_case(8'h12, 8'h20, 1'b0);
        entry_case(16'h0100, 16'h0400, 16'hBEEF, 16'h0000);
        entry_case(16'h00FE, 16'h0600, 16'h1234, 16'h0402);
        chk(16'(n_flags), 16'h0000);
        end_of_test();
    end

    // watchdog: the whole run needs well under 1000 cycles
    initial
    begin
        #60000;
        n_errors++;
        end_of_test();
    end
endmodule : loop_irq_enable_thread_entry_test
`default_nettype wire

// *** verilog/lie_exec.sv ***
// execution of loop, global irq enable and thread entry instructions
// assumes fetch gives one opcode pulse and the operands, memories answer in one cycle
`timescale 1ns/1ns
`default_nettype none
// Behaviour
// - loop decrements register, branches when nonzero
// - loop unsupported on pages 10H/11H outside C0H..CFH
// - irq-on sets mode bit zero, six cycles
// - enabled core services highest pending request
// - requests pending while disabled stay, served later
// - irq-on and entry leave flags untouched
// - entry lowers stack by two, pushes pointer
// - entry: pointer=pc, pc=word at pointer, pointer+=2
module lie_exec
(
    // clock and reset
    input  wire logic        core_clk,
    input  wire logic        resetn,
    // instruction from fetch
    input  wire logic        instr_valid,
    input  wire logic [7:0]  instr_opcode,
    input  wire logic [7:0]  instr_operand,
    input  wire logic [15:0] pc_in,
    // working register read data and page state
    input  wire logic [7:0]  wreg_rdata,
    input  wire logic [7:0]  register_page_pointer,
    input  wire logic [7:0]  wreg_base,
    input  wire logic [15:0] sp_in,
    // program memory word read
    input  wire logic [15:0] pmem_rdata,
    // interrupt requests from pins (asynchronous)
    input  wire logic        irq_pin,
    // register file / stack / pc writes
    output var  logic        wreg_we,
    output var  logic [7:0]  wreg_wdata,
    output var  logic        sp_we,
    output var  logic [15:0] sp_out,
    output var  logic        stack_we,
    output var  logic [15:0] stack_addr,
    output var  logic [15:0] stack_wdata,
    output var  logic        pc_we,
    output var  logic [15:0] pc_out,
    output var  logic [15:0] pmem_addr,
    output var  logic [15:0] thread_instr_pointer,
    output var  logic [7:0]  system_mode_reg,
    output var  logic        flags_we,
    output var  logic        loop_unsupported,
    output var  logic        irq_take,
    output var  logic        busy
);
    import lie_pkg::*;

    // ------------------------------------------------------------
    // synchronised interrupt request
    // ------------------------------------------------------------
    logic irq_sync;   // request level in core domain
    lie_sync u_irq_sync
    (
        .core_clk (core_clk),
        .resetn   (resetn),
        .din      (irq_pin),
        .dout     (irq_sync)
    );

    // ------------------------------------------------------------
    // state of the block
    // ------------------------------------------------------------
    typedef struct packed {
        lie_state_e  st;        // sequencer
        logic [4:0]  cnt;       // cycles left in instruction
        logic        pend;      // request kept while disabled
        logic        wreg_we;
        logic [7:0]  wreg_wdata;
        logic        sp_we;
        logic [15:0] sp;
        logic        stack_we;
        logic [15:0] stack_addr;
        logic [15:0] stack_wdata;
        logic        pc_we;
        logic [15:0] pc;
        logic [15:0] pmem_addr;
        logic [15:0] tptr;      // thread instruction pointer
        logic [7:0]  mode;      // system mode register
        logic        unsup;
        logic        irq_take;
        logic        busy;
    } lie_state_s;

    lie_state_s s_reg;    // registered state
    lie_state_s s_next;   // next state

    logic [7:0]  dec_val;   // decremented loop register
    logic [15:0] br_target; // relative branch target
    logic [4:0]  loop_len;  // cycle count of loop op

    // ------------------------------------------------------------
    // next-state logic
    // ------------------------------------------------------------
    always_comb
    begin
        s_next          = s_reg;
        s_next.wreg_we  = 1'b0;
        s_next.sp_we    = 1'b0;
        s_next.stack_we = 1'b0;
        s_next.pc_we    = 1'b0;
        s_next.irq_take = 1'b0;
        dec_val   = wreg_rdata - 8'h01;
        br_target = pc_in + {{8{instr_operand[7]}}, instr_operand};
        loop_len  = (dec_val != 8'h00) ? 5'(LOOP_TAKEN_CYC) : 5'(LOOP_FALL_CYC);
        // requests arrive only while disabled are held until enable
        if (irq_sync && !s_reg.mode[GIE_BIT])
            s_next.pend = 1'b1;
        // the priority resolver is outside; we only grant the winner
        if (s_reg.mode[GIE_BIT] && (irq_sync || s_reg.pend) && s_reg.st == LIE_IDLE)
        begin
            s_next.irq_take = 1'b1;
            s_next.pend     = 1'b0;
        end
        case (s_reg.st)
            LIE_IDLE:
            begin
                s_next.busy = 1'b0;
                if (instr_valid && !s_next.irq_take)
                begin
                    if (instr_opcode[3:0] == LOOP_OPC_LOW)
                    begin
                        // page 10H/11H outside C0H..CFH is flagged, not fixed
                        s_next.unsup = (register_page_pointer == PAGE_BAD_A ||
                                        register_page_pointer == PAGE_BAD_B) &&
                                       (wreg_base[7:4] != WREG_OK_HI);
                        s_next.wreg_we    = 1'b1;
                        s_next.wreg_wdata = dec_val;
                        s_next.pc_we      = 1'b1;
                        s_next.pc         = (dec_val != 8'h00) ? br_target : pc_in;
                        // count leaves out the accept cycle, the done cycle and the zero step
                        s_next.cnt        = loop_len - 5'd3;
                        s_next.busy       = 1'b1;
                        s_next.st         = LIE_WAIT;
                    end
                    else if (instr_opcode == IRQ_ON_OPC)
                    begin
                        s_next.mode[GIE_BIT] = 1'b1;
                        s_next.cnt  = 5'(IRQ_ON_CYC - 3);
                        s_next.busy = 1'b1;
                        s_next.st   = LIE_WAIT;
                    end
                    else if (instr_opcode == ENTRY_OPC)
                    begin
                        s_next.sp_we = 1'b1;
                        s_next.sp    = sp_in - STACK_STEP;
                        s_next.pc    = pc_in;
                        s_next.busy  = 1'b1;
                        s_next.st    = LIE_PUSH;
                    end
                end
            end
            LIE_PUSH:
            begin
                s_next.stack_we    = 1'b1;
                s_next.stack_addr  = s_reg.sp;
                s_next.stack_wdata = s_reg.tptr;
                s_next.tptr        = s_reg.pc;
                s_next.pmem_addr   = s_reg.pc;
                s_next.st          = LIE_FETCH;
            end
            LIE_FETCH:
            begin
                s_next.pc_we = 1'b1;
                s_next.pc    = pmem_rdata;
                s_next.tptr  = s_reg.tptr + PTR_STEP;
                // accept, push, fetch, done and the zero step are not in the count
                s_next.cnt   = 5'(ENTRY_CYC - 5);
                s_next.st    = LIE_WAIT;
            end
            LIE_WAIT:
            begin
                // pad to the fixed cycle count of the instruction
                if (s_reg.cnt == CNT_W0)
                    s_next.st = LIE_DONE;
                else
                    s_next.cnt = s_reg.cnt - 5'd1;
            end
            LIE_DONE:
            begin
                s_next.busy = 1'b0;
                s_next.st   = LIE_IDLE;
            end
            default:
                s_next.st = LIE_IDLE;
        endcase
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            s_reg     <= '0;
            s_reg.st  <= LIE_IDLE;
            s_reg.mode <= MODE_RESET;
        end
        else
            s_reg <= s_next;
    end

    // ------------------------------------------------------------
    // outputs straight from the state flops, flags_we tied low
    // ------------------------------------------------------------
    assign wreg_we              = s_reg.wreg_we;
    assign wreg_wdata           = s_reg.wreg_wdata;
    assign sp_we                = s_reg.sp_we;
    assign sp_out               = s_reg.sp;
    assign stack_we             = s_reg.stack_we;
    assign stack_addr           = s_reg.stack_addr;
    assign stack_wdata          = s_reg.stack_wdata;
    assign pc_we                = s_reg.pc_we;
    assign pc_out               = s_reg.pc;
    assign pmem_addr            = s_reg.pmem_addr;
    assign thread_instr_pointer = s_reg.tptr;
    assign system_mode_reg      = s_reg.mode;
    assign flags_we             = 1'b0;     // flags never written here
    assign loop_unsupported     = s_reg.unsup;
    assign irq_take             = s_reg.irq_take;
    assign busy                 = s_reg.busy;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    chk_gie_set_on: assert property (@(posedge core_clk) disable iff (!resetn)
        (s_reg.st == LIE_IDLE && instr_valid && instr_opcode == IRQ_ON_OPC && !s_next.irq_take)
        |=> system_mode_reg[GIE_BIT] ##4 busy ##1 !busy)
        else $error("irq enable timing or bit wrong");
    chk_entry_push: assert property (@(posedge core_clk) disable iff (!resetn)
        (sp_we && s_reg.st == LIE_PUSH) |=> stack_we && stack_addr == $past(sp_out))
        else $error("entry push address wrong");
    chk_entry_ip: assert property (@(posedge core_clk) disable iff (!resetn)
        (s_reg.st == LIE_FETCH) |=> pc_we && thread_instr_pointer == $past(pmem_addr) + PTR_STEP)
        else $error("entry pointer advance wrong");
    chk_loop_dec: assert property (@(posedge core_clk) disable iff (!resetn)
        (s_reg.st == LIE_IDLE && instr_valid && !s_next.irq_take && instr_opcode[3:0] == LOOP_OPC_LOW)
        |=> wreg_we && wreg_wdata == $past(wreg_rdata) - 8'h01)
        else $error("loop decrement wrong");
    chk_flags_kept: assert property (@(posedge core_clk) disable iff (!resetn)
        busy |-> !flags_we)
        else $error("flags written");
    chk_pend_kept: assert property (@(posedge core_clk) disable iff (!resetn)
        (s_reg.pend && !system_mode_reg[GIE_BIT]) |=> s_reg.pend)
        else $error("pending request lost");
    chk_irq_grant: assert property (@(posedge core_clk) disable iff (!resetn)
        irq_take |-> $past(system_mode_reg[GIE_BIT]))
        else $error("interrupt taken while disabled");
    chk_unsup_flag: assert property (@(posedge core_clk) disable iff (!resetn)
        (s_reg.st == LIE_IDLE && instr_valid && !s_next.irq_take && instr_opcode[3:0] == LOOP_OPC_LOW
         && register_page_pointer == PAGE_BAD_A && wreg_base[7:4] != WREG_OK_HI) |=> loop_unsupported)
        else $error("unsupported loop not flagged");
endmodule : lie_exec
`default_nettype wire

// *** verilog/lie_pkg.sv ***
// package for the loop / irq-enable / thread-entry execution block
// assumes a single core clock and an 8-bit core with 16-bit program counter
`default_nettype none
package lie_pkg;
    // ------------------------------------------------------------
    // opcodes and instruction timing
    // ------------------------------------------------------------
    localparam logic [3:0] LOOP_OPC_LOW     = 4'hA;   // loop opcode is rA, r = 0..F
    localparam logic [7:0] IRQ_ON_OPC       = 8'h9F;  // global interrupt enable
    localparam logic [7:0] ENTRY_OPC        = 8'h1F;  // threaded-code entry
    localparam int         LOOP_TAKEN_CYC   = 12;     // loop, branch taken
    localparam int         LOOP_FALL_CYC    = 10;     // loop, no branch
    localparam int         IRQ_ON_CYC       = 6;
    localparam int         ENTRY_CYC        = 20;
    localparam logic [15:0] STACK_STEP      = 16'h0002; // entry push size
    localparam logic [15:0] PTR_STEP        = 16'h0002; // word advance of pointer
    localparam int          GIE_BIT         = 0;        // enable bit in system mode reg
    // ------------------------------------------------------------
    // restricted register page case for the loop instruction
    // ------------------------------------------------------------
    localparam logic [7:0] PAGE_BAD_A       = 8'h11;
    localparam logic [7:0] PAGE_BAD_B       = 8'h10;
    localparam logic [3:0] WREG_OK_HI       = 4'hC;   // working area C0H..CFH
    localparam logic [7:0] MODE_RESET       = 8'h00;
    localparam logic [4:0] CNT_W0           = 5'h00;
    // ------------------------------------------------------------
    // sequencer states
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        LIE_IDLE, LIE_WAIT, LIE_PUSH, LIE_FETCH, LIE_DONE
    } lie_state_e;
endpackage : lie_pkg
`default_nettype wire

// *** verilog/lie_sync.sv ***
// three-flop input synchroniser with agreement of last two stages
// assumes the input may come from outside the core clock domain
`timescale 1ns/1ns
`default_nettype none
module lie_sync
(
    // clock and reset
    input  wire logic core_clk,
    input  wire logic resetn,
    // level in and out
    input  wire logic din,
    output var  logic dout
);
    typedef struct packed {
        logic [2:0] sh;     // sh[0] is read only by sh[1]
        logic       lvl;    // filtered level
    } lie_sync_s;

    lie_sync_s s_reg;    // registered state
    lie_sync_s s_next;   // next state

    // ------------------------------------------------------------
    // shift and agree
    // ------------------------------------------------------------
    always_comb
    begin
        s_next    = s_reg;
        s_next.sh = {s_reg.sh[1:0], din};
        // change counts only once stages two and three agree
        if (s_reg.sh[1] == s_reg.sh[2])
            s_next.lvl = s_reg.sh[2];
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
            s_reg <= '0;
        else
            s_reg <= s_next;
    end
    assign dout = s_reg.lvl;
endmodule : lie_sync
`default_nettype wire
